// >>> rtl/glue_pkg.sv
package glue_pkg;
    // ************************************************************
    // Wait-state and timing constants
    // ************************************************************
    localparam int unsigned WAIT_CYCLES = 256;
    localparam int unsigned WAIT_W = 9;
    localparam logic [WAIT_W-1:0] WAIT_RESET = 9'h000;
    localparam int unsigned GRANT_PULSE_CYCLES = 1;
    // Request/grant line idle level (active low)
    localparam logic RG_IDLE = 1'b1;
    localparam logic RG_ACTIVE = 1'b0;
    // Strap level selecting legacy-CPU mode
    localparam logic STRAP_LEGACY = 1'b1;

    typedef enum logic {
        MODE_INTEGRATED,
        MODE_LEGACY
    } cpu_mode_t;

    typedef struct packed {
        logic s1;
        logic s0;
    } queue_state_t;

    // Two-way pin carrier
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;
endpackage

// >>> rtl/hold_ready_bank_select_glue.sv
// Behaviour
// - Integrated mode, coprocessor owns bus: third-master hold becomes request/grant on line b.
// - Legacy mode: third-master hold becomes request/grant sequence on line b.
// - Third-master hold request is asynchronous; synchronise before use.
// - Ready output merges synced async ready, sync ready and wait-state signal.
// - Ready tied high: output high after first 256 cycles past reset.
// - Only the rising edge of async ready is synchronised.
// - Queue-status inputs are retimed onto queue-status outputs.
// - Bank select input is forwarded to bank select output.
// - Bank select output low when input low or coprocessor owns bus.
// - Hold-ack strap at reset release: high legacy, low integrated.
// - Integrated mode, CPU owns bus, third master requesting: CPU hold ack routed to its ack.
// - Request/grant lines are bidirectional, active low.
// - Integrated mode: CPU hold output high when coprocessor or third master requests; legacy mode keeps it low.
`timescale 1ns/1ns
module hold_ready_bank_select_glue #(
    parameter int unsigned WAIT_CYCLES = glue_pkg::WAIT_CYCLES
) (
    input wire logic ref_clk, // System clock
    input wire logic nrst, // Synchronous reset, low active
    input wire logic third_master_hold_req, // Async hold from third master
    output logic third_master_hold_ack, // Grant to third master
    output logic cpu_hold, // Hold request toward CPU
    input wire logic hold_ack, // CPU hold ack, also mode strap
    input wire logic req_grant_a_i, // Coprocessor request/grant level
    output logic req_grant_a_o, // Drive value, line a
    output logic req_grant_a_oe, // Drive enable, line a
    input wire logic req_grant_b_i, // Request/grant b level
    output logic req_grant_b_o, // Drive value, line b
    output logic req_grant_b_oe, // Drive enable, line b
    input wire logic sync_ready_in, // Synchronous ready
    input wire logic async_ready_in, // Asynchronous ready
    output logic merged_ready_out, // Merged ready
    input wire logic queue_state_in0, // CPU queue status bit 0
    input wire logic queue_state_in1, // CPU queue status bit 1
    output logic queue_state_out0, // Retimed queue status bit 0
    output logic queue_state_out1, // Retimed queue status bit 1
    input wire logic bank_select_in_n, // Bank select in, low active
    output logic bank_select_out_n // Bank select out, low active
);
    initial begin
        if (WAIT_CYCLES < 1 || WAIT_CYCLES >= (1 << glue_pkg::WAIT_W)) begin
            $error("WAIT_CYCLES out of range");
        end
    end

    // ************************************************************
    // Synchronisers and strap capture
    // ************************************************************
    logic hreq_s1_q, hreq_s2_q;
    logic async_ready_in_s1_q, async_ready_in_s2_q;
    logic rga_s1_q, rga_s2_q, rga_s3_q;
    logic rgb_s1_q, rgb_s2_q, rgb_s3_q;
    logic hack_s1_q, hack_s2_q;
    logic rga_own1_q, rga_own2_q, rgb_own1_q, rgb_own2_q;
    logic in_reset_q;
    glue_pkg::cpu_mode_t mode_q;

    always_ff @(posedge ref_clk) begin
        hreq_s1_q <= third_master_hold_req;
        hreq_s2_q <= hreq_s1_q;
        async_ready_in_s1_q <= async_ready_in;
        async_ready_in_s2_q <= async_ready_in_s1_q;
        rga_s1_q <= req_grant_a_i;
        rga_s2_q <= rga_s1_q;
        rga_s3_q <= rga_s2_q;
        rgb_s1_q <= req_grant_b_i;
        rgb_s2_q <= rgb_s1_q;
        rgb_s3_q <= rgb_s2_q;
        hack_s1_q <= hold_ack;
        hack_s2_q <= hack_s1_q;
        rga_own1_q <= req_grant_a_oe;
        rga_own2_q <= rga_own1_q;
        rgb_own1_q <= req_grant_b_oe;
        rgb_own2_q <= rgb_own1_q;
    end

    always_ff @(posedge ref_clk) begin
        in_reset_q <= !nrst;
        if (in_reset_q && nrst) begin
            mode_q <= (hack_s2_q == glue_pkg::STRAP_LEGACY) ?
                glue_pkg::MODE_LEGACY : glue_pkg::MODE_INTEGRATED;
        end else if (!nrst) begin
            mode_q <= glue_pkg::MODE_INTEGRATED;
        end
    end

    // Active-low pulses on request/grant lines, as seen after sync
    // Own drive returns through the sync two edges late and is masked
    wire rga_pulse = rga_s3_q && !rga_s2_q && !rga_own2_q;
    wire rgb_pulse = rgb_s3_q && !rgb_s2_q && !rgb_own2_q;
    wire legacy = (mode_q == glue_pkg::MODE_LEGACY);

    // ************************************************************
    // Bus arbitration
    // ************************************************************
    typedef enum logic [3:0] {
        ST_CPU,       // CPU owns bus
        ST_T_HOLD,    // Third master waits on CPU hold ack
        ST_T_OWN,     // Third master owns via CPU hold
        ST_C_HOLD,    // Coprocessor waits on CPU hold ack
        ST_C_GRANT,   // Grant pulse to coprocessor
        ST_C_OWN,     // Coprocessor owns bus
        ST_C_REL,     // Coprocessor released, drop hold
        ST_B_REQ,     // Request pulse on line b
        ST_B_WAIT,    // Await grant pulse on line b
        ST_B_OWN,     // Third master owns via line b
        ST_B_REL      // Release pulse on line b
    } arb_state_t;

    arb_state_t st_q, st_d;
    logic rgb_drive_d;

    always_comb begin
        st_d = st_q;
        rgb_drive_d = glue_pkg::RG_IDLE;
        unique case (st_q)
            ST_CPU: begin
                if (hreq_s2_q) begin
                    st_d = legacy ? ST_B_REQ : ST_T_HOLD;
                end else if (!legacy && rga_pulse) begin
                    st_d = ST_C_HOLD;
                end
            end
            ST_T_HOLD: begin
                if (!hreq_s2_q) begin
                    st_d = ST_CPU;
                end else if (hack_s2_q) begin
                    st_d = ST_T_OWN;
                end
            end
            ST_T_OWN: begin
                if (!hreq_s2_q) begin
                    st_d = ST_CPU;
                end
            end
            ST_C_HOLD: begin
                if (hack_s2_q) begin
                    st_d = ST_C_GRANT;
                end
            end
            ST_C_GRANT: begin
                st_d = ST_C_OWN;
            end
            ST_C_OWN: begin
                if (rga_pulse) begin
                    st_d = ST_C_REL;
                end else if (hreq_s2_q) begin
                    st_d = ST_B_REQ;
                end
            end
            ST_C_REL: begin
                st_d = ST_CPU;
            end
            ST_B_REQ: begin
                rgb_drive_d = glue_pkg::RG_ACTIVE;
                st_d = ST_B_WAIT;
            end
            ST_B_WAIT: begin
                if (rgb_pulse) begin
                    st_d = ST_B_OWN;
                end
            end
            ST_B_OWN: begin
                if (!hreq_s2_q) begin
                    st_d = ST_B_REL;
                end
            end
            ST_B_REL: begin
                rgb_drive_d = glue_pkg::RG_ACTIVE;
                st_d = legacy ? ST_CPU : ST_C_OWN;
            end
            default: begin
                st_d = ST_CPU;
            end
        endcase
    end

    // Coprocessor holds bus, including while lending it on line b
    wire copro_owns = (st_d == ST_C_OWN) || (st_d == ST_C_GRANT) ||
        (!legacy && ((st_d == ST_B_REQ) || (st_d == ST_B_WAIT) ||
        (st_d == ST_B_OWN) || (st_d == ST_B_REL)));
    wire hold_d = !legacy && (st_d != ST_CPU);
    wire ack_d = (st_d == ST_T_OWN) || (st_d == ST_B_OWN);
    wire rga_drive_d = (st_d == ST_C_GRANT) ? glue_pkg::RG_ACTIVE : glue_pkg::RG_IDLE;

    // ************************************************************
    // Ready merge and wait-state counter
    // ************************************************************
    logic [glue_pkg::WAIT_W-1:0] wait_cnt_q;
    logic async_ready_in_q;
    wire wait_done = (wait_cnt_q == WAIT_CYCLES[glue_pkg::WAIT_W-1:0]);
    // Rising edge retimed, falling edge taken straight from the pin
    wire async_ready_in_d = async_ready_in_s2_q && async_ready_in;
    wire ready_d = wait_done && (async_ready_in_d || sync_ready_in);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wait_cnt_q <= glue_pkg::WAIT_RESET;
        end else if (!wait_done) begin
            wait_cnt_q <= wait_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q <= ST_CPU;
            third_master_hold_ack <= 1'b0;
            cpu_hold <= 1'b0;
            req_grant_a_o <= glue_pkg::RG_IDLE;
            req_grant_a_oe <= 1'b0;
            req_grant_b_o <= glue_pkg::RG_IDLE;
            req_grant_b_oe <= 1'b0;
            merged_ready_out <= 1'b0;
            queue_state_out0 <= 1'b0;
            queue_state_out1 <= 1'b0;
            bank_select_out_n <= 1'b1;
        end else begin
            st_q <= st_d;
            third_master_hold_ack <= ack_d;
            cpu_hold <= hold_d;
            req_grant_a_o <= rga_drive_d;
            req_grant_a_oe <= (rga_drive_d == glue_pkg::RG_ACTIVE);
            req_grant_b_o <= rgb_drive_d;
            req_grant_b_oe <= (rgb_drive_d == glue_pkg::RG_ACTIVE);
            merged_ready_out <= ready_d;
            queue_state_out0 <= queue_state_in0;
            queue_state_out1 <= queue_state_in1;
            bank_select_out_n <= bank_select_in_n && !copro_owns;
        end
    end
endmodule // hold_ready_bank_select_glue

// >>> dv/hold_glue_asserts.sv
`timescale 1ns/1ns
module hold_glue_asserts #(
    parameter int unsigned WAIT_CYCLES = 8
) (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic third_master_hold_req, // Hold in
    input wire logic third_master_hold_ack, // Grant out
    input wire logic cpu_hold, // To CPU
    input wire logic hold_ack, // From CPU
    input wire logic req_grant_b_o, // Line b value
    input wire logic req_grant_b_oe, // Line b enable
    input wire logic sync_ready_in, // Ready in
    input wire logic async_ready_in, // Async ready
    input wire logic merged_ready_out, // Ready out
    input wire logic bank_select_in_n, // Bank in
    input wire logic bank_select_out_n // Bank out
);
    // ****************
    // Mode and age
    // ****************
    logic [15:0] cnt_q;
    logic up_q;
    logic legacy_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge ref_clk) begin
        cnt_q <= !nrst ? 16'h0000 : cnt_q + {15'h0000, cnt_q != 16'hffff};
        up_q <= nrst;
        if (nrst && !up_q) legacy_q <= (hold_ack == glue_pkg::STRAP_LEGACY);
    end
    sequence s_req_held;
        third_master_hold_req [*5];
    endsequence
    a_bank_fwd: assert property ($past(nrst) && !$past(bank_select_in_n) |-> !bank_select_out_n)
        else $error("bank select not forwarded");
    a_wait_low: assert property (cnt_q < WAIT_CYCLES |-> !merged_ready_out)
        else $error("ready before wait states done");
    a_sync_ready_in_pass: assert property (cnt_q > WAIT_CYCLES + 3 && $past(sync_ready_in) |-> merged_ready_out)
        else $error("sync ready not merged");
    a_async_ready_in_fall: assert property ($fell(async_ready_in) && !sync_ready_in |=> !merged_ready_out)
        else $error("async ready fall not passed");
    a_hold_pass: assert property ((up_q && !legacy_q) ##0 s_req_held |-> cpu_hold)
        else $error("hold not passed to CPU");
    a_ack_drop: assert property (!third_master_hold_req [*4] |-> !third_master_hold_ack)
        else $error("grant outlives request");
    a_ack_needs_cpu: assert property ((up_q && !legacy_q) ##0 !hold_ack [*4] |-> !third_master_hold_ack)
        else $error("grant without CPU ack");
    a_legacy_req: assert property ($rose(third_master_hold_req) && up_q && legacy_q |-> ##[2:8] (req_grant_b_oe && !req_grant_b_o))
        else $error("no request pulse on line b");
endmodule // hold_glue_asserts
bind hold_ready_bank_select_glue hold_glue_asserts #(.WAIT_CYCLES(WAIT_CYCLES)) u_chk (
    .ref_clk, .nrst, .third_master_hold_req, .third_master_hold_ack, .cpu_hold, .hold_ack,
    .req_grant_b_o, .req_grant_b_oe, .sync_ready_in, .async_ready_in, .merged_ready_out,
    .bank_select_in_n, .bank_select_out_n);

// >>> dv/far_side_model.sv
`timescale 1ns/1ns
module far_side_model (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic strap, // Mode strap
    input wire logic slow, // Slow answers
    input wire logic cpu_hold, // Hold request
    input wire logic rg_b_o, // Line b value
    input wire logic rg_b_oe, // Line b enable
    output logic hold_ack, // CPU hold ack
    output logic rg_b // Line b level
);
    // ****************
    // CPU side
    // ****************
    logic [3:0] sh_q;
    logic [2:0] gcnt_q;
    logic lent_q;
    wire b_req = rg_b_oe && !rg_b_o;
    assign hold_ack = (!nrst || strap) ? strap : (slow ? sh_q[3] : sh_q[0]);
    assign rg_b = rg_b_oe ? rg_b_o : (gcnt_q != 3'h1);
    always_ff @(posedge ref_clk) begin
        sh_q <= {sh_q[2:0], cpu_hold};
        if (!nrst) begin
            gcnt_q <= 3'h0;
            lent_q <= 1'b0;
        end else if (b_req && gcnt_q == 3'h0) begin
            gcnt_q <= lent_q ? 3'h0 : (slow ? 3'h5 : 3'h2);
            lent_q <= !lent_q;
        end else if (gcnt_q != 3'h0) begin
            gcnt_q <= gcnt_q - 3'h1;
        end
    end
endmodule // far_side_model

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned WC = 8;
    logic ref_clk, nrst, third_master_hold_req, sync_ready_in, async_ready_in, strap, slow;
    logic queue_state_in0, queue_state_in1, bank_select_in_n, third_master_hold_ack, cpu_hold;
    logic hold_ack, req_grant_a_o, req_grant_a_oe, req_grant_b_o, req_grant_b_oe;
    logic req_grant_b_i, merged_ready_out, queue_state_out0, queue_state_out1, bank_select_out_n;
    logic cop_rg;
    wire req_grant_a_i = req_grant_a_oe ? req_grant_a_o : cop_rg;
    int n_mismatch = 0;
    int n_checks = 0;
    hold_ready_bank_select_glue #(.WAIT_CYCLES(WC)) dut (.ref_clk, .nrst, .third_master_hold_req,
        .third_master_hold_ack, .cpu_hold, .hold_ack, .req_grant_a_i, .req_grant_a_o,
        .req_grant_a_oe, .req_grant_b_i, .req_grant_b_o, .req_grant_b_oe, .sync_ready_in,
        .async_ready_in, .merged_ready_out, .queue_state_in0, .queue_state_in1,
        .queue_state_out0, .queue_state_out1, .bank_select_in_n, .bank_select_out_n);
    far_side_model u_far (.ref_clk, .nrst, .strap, .slow, .cpu_hold, .rg_b_o(req_grant_b_o),
        .rg_b_oe(req_grant_b_oe), .hold_ack, .rg_b(req_grant_b_i));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_ack(input logic lvl);
        for (int i = 0; i < 40 && third_master_hold_ack !== lvl; i++) step(1);
        chk("hold ack", lvl, third_master_hold_ack);
    endtask
    task automatic do_reset(input logic mode);
        nrst = 1'b0;
        strap = mode;
        step(10);
        nrst = 1'b1;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_ready;
        step(WC);
        chk("ready early", 1'b0, merged_ready_out);
        step(1);
        chk("ready on time", 1'b1, merged_ready_out);
        step(4);
        chk("ready sync_ready_in", 1'b1, merged_ready_out);
        sync_ready_in = 1'b0;
        async_ready_in = 1'b1;
        step(1);
        chk("async_ready_in rise fast", 1'b0, merged_ready_out);
        step(4);
        chk("async_ready_in rise", 1'b1, merged_ready_out);
        async_ready_in = 1'b0;
        step(1);
        chk("async_ready_in fall", 1'b0, merged_ready_out);
    endtask
    task automatic t_queue_bank;
        for (int i = 0; i < 4; i++) begin
            {queue_state_in1, queue_state_in0} = i[1:0];
            bank_select_in_n = i[0];
            step(1);
            chk("queue0", i[0], queue_state_out0);
            chk("queue1", i[1], queue_state_out1);
            chk("bank", i[0], bank_select_out_n);
        end
    endtask
    task automatic t_hold_int(input logic s);
        slow = s;
        third_master_hold_req = 1'b1;
        step(4);
        chk("ack before cpu", 1'b0, third_master_hold_ack);
        wait_ack(1'b1);
        chk("cpu hold", 1'b1, cpu_hold);
        third_master_hold_req = 1'b0;
        wait_ack(1'b0);
        step(6);
        chk("cpu hold off", 1'b0, cpu_hold);
    endtask
    task automatic t_copro;
        slow = 1'b0;
        cop_rg = 1'b0;
        step(1);
        cop_rg = 1'b1;
        for (int i = 0; i < 40 && !(req_grant_a_oe && !req_grant_a_o); i++) step(1);
        chk("copro grant", 1'b0, req_grant_a_i);
        chk("copro hold", 1'b1, cpu_hold);
        step(1);
        chk("bank copro", 1'b0, bank_select_out_n);
        third_master_hold_req = 1'b1;
        wait_ack(1'b1);
        chk("bank lent", 1'b0, bank_select_out_n);
        third_master_hold_req = 1'b0;
        wait_ack(1'b0);
        step(6);
        chk("copro still", 1'b1, cpu_hold);
        cop_rg = 1'b0;
        step(1);
        cop_rg = 1'b1;
        step(6);
        chk("copro done", 1'b0, cpu_hold);
        chk("bank back", 1'b1, bank_select_out_n);
    endtask
    task automatic t_hold_legacy;
        step(2);
        third_master_hold_req = 1'b1;
        step(7);
        chk("legacy early ack", 1'b0, third_master_hold_ack);
        wait_ack(1'b1);
        chk("legacy hold", 1'b0, cpu_hold);
        chk("line b idle", 1'b1, req_grant_b_i);
        third_master_hold_req = 1'b0;
        wait_ack(1'b0);
        step(1);
        chk("release pulse", 1'b0, req_grant_b_i);
        step(3);
        chk("line b back", 1'b1, req_grant_b_i);
    endtask
    initial begin
        {third_master_hold_req, async_ready_in, queue_state_in0, queue_state_in1, slow} = 5'h00;
        sync_ready_in = 1'b1;
        bank_select_in_n = 1'b1;
        cop_rg = 1'b1;
        do_reset(1'b0);
        t_ready();
        t_queue_bank();
        t_hold_int(1'b0);
        t_hold_int(1'b1);
        t_copro();
        do_reset(1'b1);
        t_hold_legacy();
        give_verdict();
    end
endmodule // tb_top
